// ---- ccs_shaper.sv ----
/*
  Composite curve shaper: stored base curves, interpolation, multiplier,
  adder, floor time and high-current fixed time, with an Avalon-MM slave.
  Assumes pickup_multiple is synchronous to clk, in hundredths of pickup.
*/
// The Avalon-MM register port and the register addresses are this design's own decisions.
// Operation
// - Scale curve time by the multiplier first.
// - Add the offset time in ms.
// - Enabled floor time bounds the time below.
// - Floor and high-current times stay unscaled.
// - High-current time beats the floor time.
// - Forty-one selectable base curves, one chosen.
// - Times stored at fixed multiples, reset included.
// - Interpolate linearly between neighbouring points.
// - Points hold 16-bit times in ms.
// - Reset points 0.00-0.98, operate 1.03-20.00.
`timescale 1ns/100ps
module ccs_shaper #(
  parameter int unsigned NUM_CURVES = ccs_pkg::NUM_CURVES
) (
  input  wire logic        clk,             // 20 MHz clock.
  input  wire logic        sys_rst,         // Synchronous reset, high.
  input  wire logic [5:0]  avs_address,     // Byte address.
  input  wire logic        avs_read,        // Read request.
  input  wire logic        avs_write,       // Write request.
  input  wire logic [31:0] avs_writedata,   // Write data.
  output logic      [31:0] avs_readdata,    // Read data.
  output logic             avs_waitrequest, // Stall while high.
  input  wire logic [15:0] pickup_multiple, // Multiple, hundredths.
  output logic      [31:0] operate_time,    // Shaped time in ms.
  output logic             floor_active,    // Floor time is in force.
  output logic             hc_active        // Fixed time is in force.
);
  localparam int unsigned DEPTH = NUM_CURVES * ccs_pkg::NUM_POINTS;

  // Stored curve points, 16-bit ms each. The store powers up cleared, so
  // a curve that was never loaded reads as zero time instead of garbage.
  logic [15:0] curve_mem [DEPTH] = '{default: 16'h0000};

  logic        wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        floor_en_r, floor_en_nxt;
  logic        hc_en_r, hc_en_nxt;
  logic [5:0]  curve_sel_r, curve_sel_nxt;
  logic [15:0] mult_r, mult_nxt;
  logic [15:0] adder_r, adder_nxt;
  logic [15:0] floor_time_r, floor_time_nxt;
  logic [15:0] hc_thr_r, hc_thr_nxt;
  logic [15:0] hc_time_r, hc_time_nxt;
  logic [12:0] pt_addr_r, pt_addr_nxt;
  logic [31:0] op_r, op_nxt;
  logic        floor_hit_r, floor_hit_nxt;
  logic        hc_hit_r, hc_hit_nxt;

  logic        req, take_wr;
  logic        mem_we;
  logic [6:0]  lo_idx, hi_idx;
  logic [15:0] m0, m1, t0, t1, t_curve;
  logic [12:0] base;
  logic [31:0] scaled;

  // Curve lookup: bracket the multiple and fetch both neighbours.
  always_comb begin
    lo_idx = ccs_pkg::mult_to_idx(pickup_multiple);
    hi_idx = (lo_idx == ccs_pkg::LAST_POINT) ? lo_idx : 7'(lo_idx + 7'h01);
    m0     = ccs_pkg::point_mult(lo_idx);
    m1     = ccs_pkg::point_mult(hi_idx);
    base   = 13'({7'h00, curve_sel_r} * ccs_pkg::POINTS_W);
    t0     = curve_mem[13'(base + {6'h00, lo_idx})];
    t1     = curve_mem[13'(base + {6'h00, hi_idx})];
  end

  ccs_interp u_interp (
    .m     (pickup_multiple),
    .m0    (m0),
    .m1    (m1),
    .t0    (t0),
    .t1    (t1),
    .t_out (t_curve)
  );

  // Shaping. Only the curve part sees the multiplier and the adder.
  always_comb begin
    scaled = ({16'h0000, t_curve} * {16'h0000, mult_r})
             / ccs_pkg::PCT_SCALE;
    scaled = scaled + {16'h0000, adder_r};
    hc_hit_nxt    = hc_en_r && (pickup_multiple >= hc_thr_r);
    floor_hit_nxt = floor_en_r && !hc_hit_nxt
                    && (scaled < {16'h0000, floor_time_r});
    if (hc_hit_nxt) begin
      op_nxt = {16'h0000, hc_time_r};
    end else if (floor_hit_nxt) begin
      op_nxt = {16'h0000, floor_time_r};
    end else begin
      op_nxt = scaled;
    end
  end

  // Register bus. A request is answered two edges after it appears: the
  // first edge drops waitrequest and loads read data, the second commits.
  always_comb begin
    req      = avs_read | avs_write;
    wait_nxt = ~(req & wait_r);
    take_wr  = avs_write & ~wait_r;
    mem_we   = take_wr && (avs_address == ccs_pkg::OFS_PT_DATA);
    rdata_nxt      = rdata_r;
    floor_en_nxt   = floor_en_r;
    hc_en_nxt      = hc_en_r;
    curve_sel_nxt  = curve_sel_r;
    mult_nxt       = mult_r;
    adder_nxt      = adder_r;
    floor_time_nxt = floor_time_r;
    hc_thr_nxt     = hc_thr_r;
    hc_time_nxt    = hc_time_r;
    pt_addr_nxt    = pt_addr_r;
    if (avs_read && wait_r) begin
      case (avs_address)
        ccs_pkg::OFS_CTRL: begin
          rdata_nxt = {18'h00000, curve_sel_r, 6'h00, hc_en_r, floor_en_r};
        end
        ccs_pkg::OFS_MULT:    rdata_nxt = {16'h0000, mult_r};
        ccs_pkg::OFS_ADDER:   rdata_nxt = {16'h0000, adder_r};
        ccs_pkg::OFS_FLOOR:   rdata_nxt = {16'h0000, floor_time_r};
        ccs_pkg::OFS_HC_THR:  rdata_nxt = {16'h0000, hc_thr_r};
        ccs_pkg::OFS_HC_TIME: rdata_nxt = {16'h0000, hc_time_r};
        ccs_pkg::OFS_PT_ADDR: rdata_nxt = {19'h00000, pt_addr_r};
        ccs_pkg::OFS_PT_DATA: rdata_nxt = {16'h0000, curve_mem[pt_addr_r]};
        ccs_pkg::OFS_RESULT:  rdata_nxt = op_r;
        ccs_pkg::OFS_PICKUP: begin
          rdata_nxt = {14'h0000, hc_hit_r, floor_hit_r, pickup_multiple};
        end
        default:              rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (take_wr) begin
      case (avs_address)
        ccs_pkg::OFS_CTRL: begin
          floor_en_nxt = avs_writedata[ccs_pkg::CTRL_FLOOR_BIT];
          hc_en_nxt    = avs_writedata[ccs_pkg::CTRL_HC_BIT];
          // Out-of-range selections pin to the last curve.
          curve_sel_nxt = avs_writedata[ccs_pkg::CTRL_SEL_LSB +: 6];
          if (curve_sel_nxt > ccs_pkg::SEL_MAX) begin
            curve_sel_nxt = ccs_pkg::SEL_MAX;
          end
        end
        ccs_pkg::OFS_MULT:    mult_nxt       = avs_writedata[15:0];
        ccs_pkg::OFS_ADDER:   adder_nxt      = avs_writedata[15:0];
        ccs_pkg::OFS_FLOOR:   floor_time_nxt = avs_writedata[15:0];
        ccs_pkg::OFS_HC_THR:  hc_thr_nxt     = avs_writedata[15:0];
        ccs_pkg::OFS_HC_TIME: hc_time_nxt    = avs_writedata[15:0];
        ccs_pkg::OFS_PT_ADDR: pt_addr_nxt    = avs_writedata[12:0];
        ccs_pkg::OFS_PT_DATA: pt_addr_nxt    = 13'(pt_addr_r + 13'h0001);
        default:              pt_addr_nxt    = pt_addr_r;
      endcase
    end
  end

  // Point storage ignores sys_rst; software loads it before use.
  always_ff @(posedge clk) begin
    if (mem_we && ({19'h00000, pt_addr_r} < DEPTH)) begin
      curve_mem[pt_addr_r] <= avs_writedata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_r       <= 1'b1;
      rdata_r      <= 32'h0000_0000;
      floor_en_r   <= 1'b0;
      hc_en_r      <= 1'b0;
      curve_sel_r  <= ccs_pkg::SEL_RST;
      mult_r       <= ccs_pkg::MULT_RST;
      adder_r      <= ccs_pkg::TIME_RST;
      floor_time_r <= ccs_pkg::TIME_RST;
      hc_thr_r     <= ccs_pkg::TIME_RST;
      hc_time_r    <= ccs_pkg::TIME_RST;
      pt_addr_r    <= 13'h0000;
      op_r         <= 32'h0000_0000;
      floor_hit_r  <= 1'b0;
      hc_hit_r     <= 1'b0;
    end else begin
      wait_r       <= wait_nxt;
      rdata_r      <= rdata_nxt;
      floor_en_r   <= floor_en_nxt;
      hc_en_r      <= hc_en_nxt;
      curve_sel_r  <= curve_sel_nxt;
      mult_r       <= mult_nxt;
      adder_r      <= adder_nxt;
      floor_time_r <= floor_time_nxt;
      hc_thr_r     <= hc_thr_nxt;
      hc_time_r    <= hc_time_nxt;
      pt_addr_r    <= pt_addr_nxt;
      op_r         <= op_nxt;
      floor_hit_r  <= floor_hit_nxt;
      hc_hit_r     <= hc_hit_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata    = rdata_r;
  assign operate_time    = op_r;
  assign floor_active    = floor_hit_r;
  assign hc_active       = hc_hit_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_sel_range: assert property (curve_sel_r <= ccs_pkg::SEL_MAX)
    else $error("curve selection beyond last curve");
  chk_hc_override: assert property (
    hc_en_r && (pickup_multiple >= hc_thr_r)
    |=> hc_active && (operate_time == {16'h0000, $past(hc_time_r)}))
    else $error("fixed high-current time not applied");
  chk_hc_priority: assert property (
    hc_en_r && floor_en_r && (pickup_multiple > hc_thr_r)
    |=> !floor_active && hc_active)
    else $error("floor time overrode high-current time");
  chk_floor_min: assert property (
    floor_en_r && !(hc_en_r && (pickup_multiple >= hc_thr_r))
    |=> operate_time >= {16'h0000, $past(floor_time_r)})
    else $error("operate time below floor time");
  chk_floor_plain: assert property (
    floor_en_r && !hc_en_r && (mult_r > ccs_pkg::MULT_RST)
    && (t_curve == 16'h0000) && (adder_r < floor_time_r)
    |=> floor_active && (operate_time == {16'h0000, $past(floor_time_r)}))
    else $error("floor time was scaled or shifted");
  chk_adder_only: assert property (
    (mult_r == 16'h0000) && !floor_en_r && !hc_en_r
    |=> operate_time == {16'h0000, $past(adder_r)})
    else $error("offset time not added");
  chk_unit_mult: assert property (
    (mult_r == ccs_pkg::MULT_RST) && (adder_r == 16'h0000)
    && !floor_en_r && !hc_en_r
    |=> operate_time == {16'h0000, $past(t_curve)})
    else $error("unit multiplier changed the curve time");
  chk_interp_bound: assert property (
    ((t_curve >= t0) && (t_curve <= t1))
    || ((t_curve <= t0) && (t_curve >= t1)))
    else $error("interpolated time outside its neighbours");
  chk_idx_bracket: assert property (
    (pickup_multiple < ccs_pkg::MULT_TOP)
    |-> (m0 <= pickup_multiple) && (pickup_multiple < m1))
    else $error("pickup multiple not bracketed by points");
  chk_wait_single: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
endmodule

// ---- ccs_pkg.sv ----
/*
  Constants and point-table decoding for the composite curve shaper.
  Assumes a 32-bit Avalon-MM register bus and pickup multiples given in
  hundredths of pickup.
*/
package ccs_pkg;

  localparam int unsigned NUM_CURVES   = 41;
  localparam int unsigned NUM_POINTS   = 120;
  localparam int unsigned MEM_AW       = 13;

  // Byte offsets of the register words.
  localparam logic [5:0] OFS_CTRL      = 6'h00;
  localparam logic [5:0] OFS_MULT      = 6'h04;
  localparam logic [5:0] OFS_ADDER     = 6'h08;
  localparam logic [5:0] OFS_FLOOR     = 6'h0c;
  localparam logic [5:0] OFS_HC_THR    = 6'h10;
  localparam logic [5:0] OFS_HC_TIME   = 6'h14;
  localparam logic [5:0] OFS_PT_ADDR   = 6'h18;
  localparam logic [5:0] OFS_PT_DATA   = 6'h1c;
  localparam logic [5:0] OFS_RESULT    = 6'h20;
  localparam logic [5:0] OFS_PICKUP    = 6'h24;

  // Control word layout.
  localparam int unsigned CTRL_FLOOR_BIT = 0;
  localparam int unsigned CTRL_HC_BIT    = 1;
  localparam int unsigned CTRL_SEL_LSB   = 8;

  // Values after reset, then limits and scales; the multiplier is in hundredths, so 1.00.
  localparam logic [15:0] MULT_RST     = 16'h0064;
  localparam logic [15:0] TIME_RST     = 16'h0000;
  localparam logic [5:0]  SEL_RST      = 6'h00;
  localparam logic [5:0]  SEL_MAX      = 6'h28;
  localparam logic [31:0] PCT_SCALE    = 32'h0000_0064;
  localparam logic [15:0] MULT_TOP     = 16'h07d0;
  localparam logic [6:0]  LAST_POINT   = 7'h77;
  localparam logic [12:0] POINTS_W     = 13'h0078;

  // Multiple, in hundredths, at which stored point i sits.
  function automatic logic [15:0] point_mult(input logic [6:0] i);
    logic [15:0] w;
    w = {9'h000, i};
    if (i < 7'h0a) point_mult = w * 16'h0005;
    else if (i < 7'h20) point_mult = 16'h0030 + (w - 16'h000a) * 16'h0002;
    else if (i < 7'h28) point_mult = 16'h005b + (w - 16'h0020);
    else if (i == 7'h28) point_mult = 16'h0067;
    else if (i == 7'h29) point_mult = 16'h0069;
    else if (i < 7'h5c) point_mult = 16'h006e + (w - 16'h002a) * 16'h000a;
    else point_mult = 16'h0258 + (w - 16'h005b) * 16'h0032;
  endfunction

  // Index of the highest stored point at or below multiple m.
  function automatic logic [6:0] mult_to_idx(input logic [15:0] m);
    logic [15:0] q;
    q = 16'h0000;
    if (m >= MULT_TOP) q = {9'h000, LAST_POINT};
    else if (m < 16'h0030) q = m / 16'h0005;
    else if (m < 16'h005b) q = 16'h000a + (m - 16'h0030) / 16'h0002;
    else if (m < 16'h0063) q = 16'h0020 + (m - 16'h005b);
    else if (m < 16'h0067) q = 16'h0027;
    else if (m < 16'h0069) q = 16'h0028;
    else if (m < 16'h006e) q = 16'h0029;
    else if (m < 16'h0258) q = 16'h002a + (m - 16'h006e) / 16'h000a;
    else q = 16'h005b + (m - 16'h0258) / 16'h0032;
    mult_to_idx = q[6:0];
  endfunction

endpackage

// ---- ccs_interp.sv ----
/*
  Straight-line interpolation between two neighbouring curve points.
  Purely combinational; expects m0 <= m <= m1, or m1 equal to m0 when the
  multiple lies past the last stored point.
*/
`timescale 1ns/100ps
module ccs_interp (
  input  wire logic [15:0] m,      // Present multiple.
  input  wire logic [15:0] m0,     // Multiple of the lower point.
  input  wire logic [15:0] m1,     // Multiple of the upper point.
  input  wire logic [15:0] t0,     // Time at the lower point.
  input  wire logic [15:0] t1,     // Time at the upper point.
  output logic      [15:0] t_out   // Interpolated time.
);
  logic signed [17:0] dt;
  logic signed [35:0] prod;
  logic signed [35:0] quot;
  logic signed [35:0] res;

  always_comb begin
    dt   = $signed({2'b00, t1}) - $signed({2'b00, t0});
    prod = 36'(dt * $signed({2'b00, m - m0}));
    quot = 36'sh0;
    // A zero span means a clamped end point, so the lower time stands.
    if (m1 != m0) begin
      quot = prod / $signed({20'h00000, m1 - m0});
    end
    res   = $signed({20'h00000, t0}) + quot;
    t_out = res[15:0];
  end
endmodule

// ---- test_ccs_shaper.sv ----
/*
  Self-checking testbench for the composite curve shaper.
  Assumes the Avalon-MM slave answers after one wait cycle and that the
  shaped outputs follow their inputs one clock edge later.
*/
`timescale 1ns/100ps
`define CHECK(nm, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); \
  end \
end
module test_ccs_shaper;
  logic        clk             = 1'b0;
  logic        sys_rst         = 1'b1;
  logic [5:0]  avs_address     = 6'h00;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] pickup_multiple = 16'h0000;
  logic [31:0] operate_time;
  logic        floor_active;
  logic        hc_active;
  logic [31:0] rd;
  int          fail_count      = 0;
  int          checked         = 0;
  int          cycles          = 0;

  ccs_shaper uut (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .pickup_multiple (pickup_multiple),
    .operate_time    (operate_time),
    .floor_active    (floor_active),
    .hc_active       (hc_active)
  );

  always #25 clk = ~clk;

  // The whole run needs well under 3000 cycles; a hang ends it here.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic bus_write(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write     <= 1'b0;
  endtask

  task automatic bus_read(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read    <= 1'b0;
  endtask

  task automatic read_chk(input logic [5:0] a, input logic [31:0] e);
    bus_read(a, rd);
    `CHECK("register", e, rd)
  endtask

  // Points fall by step per index so every curve stays non-rising.
  task automatic load_curve(input int c, input int base, input int step);
    bus_write(ccs_pkg::OFS_PT_ADDR, 32'(c * ccs_pkg::NUM_POINTS));
    for (int i = 0; i < ccs_pkg::NUM_POINTS; i++) begin
      bus_write(ccs_pkg::OFS_PT_DATA, 32'(base - step * i));
    end
  endtask

  // The output is looked at exactly one edge after the multiple changes.
  task automatic pk_chk(input logic [15:0] m, input logic [31:0] t,
                        input logic fl, input logic hc);
    @(posedge clk);
    pickup_multiple <= m;
    @(posedge clk);
    #1;
    `CHECK("operate_time", t, operate_time)
    `CHECK("floor_active", fl, floor_active)
    `CHECK("hc_active", hc, hc_active)
  endtask

  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    `CHECK("reset operate_time", 32'h0000_0000, operate_time)
    read_chk(ccs_pkg::OFS_CTRL, 32'h0000_0000);
    read_chk(ccs_pkg::OFS_MULT, 32'h0000_0064);
    read_chk(ccs_pkg::OFS_ADDER, 32'h0000_0000);
    bus_write(6'h28, 32'h0000_1234);
    read_chk(6'h28, 32'h0000_0000);
    $display("test reset and map done");

    load_curve(0, 2000, 10);
    load_curve(40, 500, 0);
    bus_write(ccs_pkg::OFS_PT_ADDR, 32'h0000_0005);
    bus_write(ccs_pkg::OFS_PT_DATA, 32'h0000_ffff);
    bus_write(ccs_pkg::OFS_PT_ADDR, 32'h0000_0005);
    read_chk(ccs_pkg::OFS_PT_DATA, 32'h0000_ffff);
    bus_write(ccs_pkg::OFS_PT_ADDR, 32'h0000_0006);
    read_chk(ccs_pkg::OFS_PT_DATA, 32'h0000_0794);
    $display("test point store done");

    pk_chk(16'h0067, 32'd1600, 1'b0, 1'b0);
    pk_chk(16'h0073, 32'd1575, 1'b0, 1'b0);
    pk_chk(16'h07d0, 32'd810, 1'b0, 1'b0);
    pk_chk(16'h09c4, 32'd810, 1'b0, 1'b0);
    $display("test base curve done");

    bus_write(ccs_pkg::OFS_MULT, 32'd200);
    bus_write(ccs_pkg::OFS_ADDER, 32'd50);
    pk_chk(16'h0067, 32'd3250, 1'b0, 1'b0);
    pk_chk(16'h0000, 32'd4050, 1'b0, 1'b0);
    $display("test multiplier and adder done");

    // Threshold is still 0, so a wrong enable would show the fixed time.
    bus_write(ccs_pkg::OFS_FLOOR, 32'd3300);
    bus_write(ccs_pkg::OFS_CTRL, 32'h0000_0001);
    pk_chk(16'h0067, 32'd3300, 1'b1, 1'b0);
    read_chk(ccs_pkg::OFS_PICKUP, 32'h0001_0067);
    pk_chk(16'h0000, 32'd4050, 1'b0, 1'b0);
    $display("test floor time done");

    bus_write(ccs_pkg::OFS_HC_THR, 32'h0000_0067);
    bus_write(ccs_pkg::OFS_HC_TIME, 32'd20);
    bus_write(ccs_pkg::OFS_CTRL, 32'h0000_0003);
    pk_chk(16'h0066, 32'd3300, 1'b1, 1'b0);
    pk_chk(16'h0067, 32'd20, 1'b0, 1'b1);
    pk_chk(16'h09c4, 32'd20, 1'b0, 1'b1);
    read_chk(ccs_pkg::OFS_PICKUP, 32'h0002_09c4);
    $display("test high-current time done");

    bus_write(ccs_pkg::OFS_CTRL, 32'h0000_3f00);
    read_chk(ccs_pkg::OFS_CTRL, 32'h0000_2800);
    pk_chk(16'h0067, 32'd1050, 1'b0, 1'b0);
    bus_write(ccs_pkg::OFS_RESULT, 32'h0000_1234);
    read_chk(ccs_pkg::OFS_RESULT, 32'd1050);
    $display("test curve select done");

    // A zero point under a doubled multiplier must still yield the floor.
    bus_write(ccs_pkg::OFS_PT_ADDR, 32'd4919);
    bus_write(ccs_pkg::OFS_PT_DATA, 32'h0000_0000);
    read_chk(ccs_pkg::OFS_PT_ADDR, 32'd4920);
    bus_write(ccs_pkg::OFS_CTRL, 32'h0000_2801);
    pk_chk(16'h07d0, 32'd3300, 1'b1, 1'b0);
    bus_write(ccs_pkg::OFS_CTRL, 32'h0000_2800);
    bus_write(ccs_pkg::OFS_MULT, 32'h0000_0000);
    pk_chk(16'h0067, 32'd50, 1'b0, 1'b0);
    $display("test floor and offset corners done");
    results();
  end
endmodule
